// *** logic/sbs_core.sv ***
module sbs_core (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire sbs_pkg::sbs_bus_t bus_in,
   input wire logic miso_in,
   input wire logic ss_n_in,
   output logic [7:0] rdata_out,
   output logic sck_out,
   output logic mosi_out,
   output logic irq_tx_out,
   output logic irq_rx_out,
   output logic irq_out
);
   import sbs_pkg::*;

   logic [7:0] ctrl1_q, ctrl2_q, rate_q;
   logic [7:0] txbuf_q, shift_q, rxbuf_q;
   logic txfull_q;
   logic rxf_q, txe_q, mode_fault_flag_q;
   logic arm_rxf_q, arm_txe_q, arm_mode_fault_flag_q;
   logic [EV_W-1:0] ev_stat_q, ev_en_q;
   sbs_shift_t state_q;
   logic [2:0] pre_cnt_q;
   logic [7:0] div_cnt_q;
   logic [4:0] edge_cnt_q;
   logic sck_q, mosi_q;
   logic [1:0] miso_sync_q, ss_sync_q;
   logic [7:0] rdata_q;
   logic irq_tx_q, irq_rx_q, irq_q;

   logic enabled, master, fault_mode, pre_tick, bit_tick, done, load, data_wr, fault;
   logic [7:0] div_max;

   assign enabled = ctrl1_q[C1_ENABLE];
   assign master = ctrl1_q[C1_MASTER];
   assign fault_mode = master && ctrl2_q[C2_FAULT_EN] && !ctrl1_q[C1_SELECT_OUTPUT_ENABLE];
   assign fault = enabled && fault_mode && !ss_sync_q[1];

   // Pin inputs pass two flops before use
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         miso_sync_q <= 2'h0;
         ss_sync_q <= 2'h3;
      end else begin
         miso_sync_q <= {miso_sync_q[0], miso_in};
         ss_sync_q <= {ss_sync_q[0], ss_n_in};
      end
   end

   // Plain register writes; status writes fall through unused
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctrl1_q <= C1_RESET;
         ctrl2_q <= C2_RESET;
         rate_q <= BR_RESET;
         ev_en_q <= '0;
      end else if (bus_in.wr) begin
         unique case (bus_in.addr)
            ADDR_CTRL1: ctrl1_q <= bus_in.wdata;
            ADDR_CTRL2: ctrl2_q <= bus_in.wdata & C2_MASK;
            ADDR_RATE: rate_q <= bus_in.wdata & BR_MASK;
            ADDR_IRQ_EN: ev_en_q <= bus_in.wdata[EV_W-1:0];
            default: ;
         endcase
      end
   end

   // Prescaler: counts to field value, so divide is field plus one
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pre_cnt_q <= 3'h0;
      end else if (state_q != SH_BUSY || pre_tick) begin
         pre_cnt_q <= 3'h0;
      end else begin
         pre_cnt_q <= pre_cnt_q + 3'h1;
      end
   end
   assign pre_tick = (state_q == SH_BUSY) && (pre_cnt_q == rate_q[BR_PRE_LSB +: 3]);

   // Rate divider: a tick every half period toggles the bit clock
   assign div_max = 8'((8'h01 << rate_q[BR_RATE_LSB +: 3]) - 8'h01);
   assign bit_tick = pre_tick && (div_cnt_q == div_max);
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         div_cnt_q <= 8'h00;
      end else if (state_q != SH_BUSY || bit_tick) begin
         div_cnt_q <= 8'h00;
      end else if (pre_tick) begin
         div_cnt_q <= div_cnt_q + 8'h01;
      end
   end

   // Data write allowed only after an armed status read
   assign data_wr = bus_in.wr && bus_in.addr == ADDR_DATA && arm_txe_q && enabled;
   assign done = bit_tick && edge_cnt_q == HALF_EDGES - 5'h01;
   assign load = enabled && master && (txfull_q || data_wr) &&
                 (state_q == SH_IDLE || done);

   // Shifter state; bit clock only starts in master mode
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= SH_IDLE;
         edge_cnt_q <= 5'h00;
         shift_q <= 8'h00;
         sck_q <= 1'b0;
         mosi_q <= 1'b0;
      end else if (!enabled || fault) begin
         state_q <= SH_IDLE;
         edge_cnt_q <= 5'h00;
         sck_q <= 1'b0;
      end else if (load) begin
         state_q <= SH_BUSY;
         edge_cnt_q <= 5'h00;
         shift_q <= txfull_q ? txbuf_q : bus_in.wdata;
         mosi_q <= txfull_q ? txbuf_q[7] : bus_in.wdata[7];
         sck_q <= 1'b0;
      end else if (done) begin
         state_q <= SH_IDLE;
         sck_q <= 1'b0;
      end else if (bit_tick) begin
         sck_q <= ~sck_q;
         edge_cnt_q <= edge_cnt_q + 5'h01;
         if (!sck_q) begin
            shift_q <= {shift_q[6:0], miso_sync_q[1]};
         end else begin
            mosi_q <= shift_q[7];
         end
      end
   end

   // Transmit buffer; queued when shifter busy
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         txfull_q <= 1'b0;
         txbuf_q <= 8'h00;
      end else if (!enabled) begin
         txfull_q <= 1'b0;
      end else if (data_wr && !load) begin
         txfull_q <= 1'b1;
         txbuf_q <= bus_in.wdata;
      end else if (load && txfull_q) begin
         txfull_q <= data_wr;
         txbuf_q <= bus_in.wdata;
      end
   end

   // Receive buffer; an unread byte is overwritten silently
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rxbuf_q <= 8'h00;
      end else if (done) begin
         rxbuf_q <= shift_q;
      end
   end

   // Armed bits for the read-then-access clear sequences
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         arm_rxf_q <= 1'b0;
         arm_txe_q <= 1'b0;
         arm_mode_fault_flag_q <= 1'b0;
      end else if (bus_in.rd && bus_in.addr == ADDR_STATUS) begin
         arm_rxf_q <= rxf_q;
         arm_txe_q <= txe_q;
         arm_mode_fault_flag_q <= mode_fault_flag_q;
      end else begin
         if (bus_in.rd && bus_in.addr == ADDR_DATA) begin
            arm_rxf_q <= 1'b0;
         end
         if (bus_in.wr && bus_in.addr == ADDR_DATA) begin
            arm_txe_q <= 1'b0;
         end
         if (bus_in.wr && bus_in.addr == ADDR_CTRL1) begin
            arm_mode_fault_flag_q <= 1'b0;
         end
      end
   end

   // Receive-full: set wins over the clearing read
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rxf_q <= 1'b0;
      end else if (!enabled) begin
         rxf_q <= 1'b0;
      end else if (done) begin
         rxf_q <= 1'b1;
      end else if (bus_in.rd && bus_in.addr == ADDR_DATA && arm_rxf_q) begin
         rxf_q <= 1'b0;
      end
   end

   // Transmit-empty: tracks room in the buffer after this cycle
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         txe_q <= 1'b1;
      end else if (!enabled) begin
         txe_q <= 1'b1;
      end else if (load && !(txfull_q && data_wr)) begin
         txe_q <= 1'b1;
      end else if (data_wr) begin
         txe_q <= 1'b0;
      end
   end

   // Mode fault: set wins over the control write clear
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_fault_flag_q <= 1'b0;
      end else if (fault) begin
         mode_fault_flag_q <= 1'b1;
      end else if (bus_in.wr && bus_in.addr == ADDR_CTRL1 && arm_mode_fault_flag_q) begin
         mode_fault_flag_q <= 1'b0;
      end
   end

   // Sticky event bits, one flop per event; set wins over the write-one clear
   for (genvar i = 0; i < EV_W; i++) begin : g_ev
      always_ff @(posedge clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            ev_stat_q[i] <= 1'b0;
         end else if ((i == EV_DONE && done) || (i == EV_FAULT && fault)) begin
            ev_stat_q[i] <= 1'b1;
         end else if (bus_in.wr && bus_in.addr == ADDR_IRQ_CLR && bus_in.wdata[i]) begin
            ev_stat_q[i] <= 1'b0;
         end
      end
   end

   // Interrupt outputs, registered
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_tx_q <= 1'b0;
         irq_rx_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         irq_tx_q <= txe_q && ctrl1_q[C1_TX_IE];
         irq_rx_q <= (rxf_q || mode_fault_flag_q) && ctrl1_q[C1_RXF_IE];
         irq_q <= |(ev_stat_q & ev_en_q);
      end
   end

   // Read data, valid the cycle after the strobe
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_q <= 8'h00;
      end else if (bus_in.rd) begin
         unique case (bus_in.addr)
            ADDR_CTRL1: rdata_q <= ctrl1_q;
            ADDR_CTRL2: rdata_q <= ctrl2_q;
            ADDR_RATE: rdata_q <= rate_q;
            ADDR_STATUS: rdata_q <= {rxf_q, 1'b0, txe_q, mode_fault_flag_q, 4'h0};
            ADDR_DATA: rdata_q <= rxbuf_q;
            ADDR_IRQ_STAT: rdata_q <= {6'h00, ev_stat_q};
            ADDR_IRQ_EN: rdata_q <= {6'h00, ev_en_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata_out = rdata_q;
   assign sck_out = sck_q;
   assign mosi_out = mosi_q;
   assign irq_tx_out = irq_tx_q;
   assign irq_rx_out = irq_rx_q;
   assign irq_out = irq_q;
endmodule

// *** logic/sbs_pkg.sv ***
package sbs_pkg;
   // Register addresses on the plain register port
   localparam logic [2:0] ADDR_CTRL1 = 3'h0;
   localparam logic [2:0] ADDR_CTRL2 = 3'h1;
   localparam logic [2:0] ADDR_RATE = 3'h2;
   localparam logic [2:0] ADDR_STATUS = 3'h3;
   localparam logic [2:0] ADDR_DATA = 3'h4;
   localparam logic [2:0] ADDR_IRQ_STAT = 3'h5;
   localparam logic [2:0] ADDR_IRQ_CLR = 3'h6;
   localparam logic [2:0] ADDR_IRQ_EN = 3'h7;
   // Control register one fields
   localparam int C1_RXF_IE = 7;
   localparam int C1_ENABLE = 6;
   localparam int C1_TX_IE = 5;
   localparam int C1_MASTER = 4;
   localparam int C1_SELECT_OUTPUT_ENABLE = 1;
   // Control register two fields
   localparam int C2_FAULT_EN = 4;
   localparam logic [7:0] C2_MASK = 8'h1B;
   // Rate register fields
   localparam int BR_PRE_LSB = 4;
   localparam int BR_RATE_LSB = 0;
   localparam logic [7:0] BR_MASK = 8'h77;
   // Status register fields
   localparam int ST_RXF = 7;
   localparam int ST_TXE = 5;
   localparam int ST_MODE_FAULT_FLAG = 4;
   // Event status bits: 0 byte done, 1 mode fault
   localparam int EV_DONE = 0;
   localparam int EV_FAULT = 1;
   localparam int EV_W = 2;
   // Reset values
   localparam logic [7:0] C1_RESET = 8'h04;
   localparam logic [7:0] C2_RESET = 8'h00;
   localparam logic [7:0] BR_RESET = 8'h00;
   // Half periods per byte transfer; two bit-clock half periods per bit
   localparam logic [4:0] HALF_EDGES = 5'h10;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sbs_bus_t;

   typedef enum logic [1:0] {
      SH_IDLE = 2'b01,
      SH_BUSY = 2'b10
   } sbs_shift_t;
endpackage

// *** dv/sbs_core_properties.sv ***
module sbs_chk (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire sbs_pkg::sbs_bus_t bus_in,
   input wire logic [7:0] rdata_out,
   input wire logic sck_out,
   input wire logic irq_tx_out,
   input wire logic irq_rx_out,
   input wire logic irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import sbs_pkg::*;
   logic [7:0] c1_q, c2_q, br_q;
   logic cfg_q;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // Shadow the control writes so the gates can be judged from the ports alone
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         c1_q <= C1_RESET;
         c2_q <= C2_RESET;
         br_q <= BR_RESET;
         cfg_q <= 1'b0;
      end else begin
         if (bus_in.wr && bus_in.addr == ADDR_CTRL1) c1_q <= bus_in.wdata;
         if (bus_in.wr && bus_in.addr == ADDR_CTRL2) c2_q <= bus_in.wdata & C2_MASK;
         if (bus_in.wr && bus_in.addr == ADDR_RATE) br_q <= bus_in.wdata & BR_MASK;
         // Sticky: a fault raised under a legal setup outlives that setup
         cfg_q <= cfg_q | (c1_q[C1_MASTER] & c2_q[C2_FAULT_EN] & ~c1_q[C1_SELECT_OUTPUT_ENABLE]);
      end
   end
   status_pad_a: assert property (bus_in.rd && bus_in.addr == ADDR_STATUS
      |=> (rdata_out & 8'h4F) == 8'h00) else $error("status pad bits set");
   rate_read_a: assert property (bus_in.rd && bus_in.addr == ADDR_RATE
      |=> rdata_out == $past(br_q)) else $error("rate readback differs");
   tx_irq_gate_a: assert property (irq_tx_out |-> $past(c1_q[C1_TX_IE]))
      else $error("tx irq without enable");
   rx_irq_gate_a: assert property (irq_rx_out |-> $past(c1_q[C1_RXF_IE]))
      else $error("rx irq without enable");
   sck_master_a: assert property ($rose(sck_out)
      |-> $past(c1_q[C1_ENABLE] && c1_q[C1_MASTER])) else $error("sck outside master");
   fault_cfg_a: assert property (bus_in.rd && bus_in.addr == ADDR_STATUS && !cfg_q
      |=> !rdata_out[ST_MODE_FAULT_FLAG]) else $error("fault flag without setup");
   disable_stop_a: assert property (bus_in.wr && bus_in.addr == ADDR_CTRL1
      && !bus_in.wdata[C1_ENABLE] |=> ##1 !sck_out [*3]) else $error("sck after disable");
   half_width_a: assert property ($changed(sck_out) && br_q != 8'h00
      |=> $stable(sck_out)) else $error("sck half period too short");
   cover property ($rose(irq_out));
   cover property ($rose(irq_rx_out));
   cover property (bus_in.rd && bus_in.addr == ADDR_STATUS ##1 rdata_out[ST_MODE_FAULT_FLAG]);
endmodule
bind sbs_core sbs_chk u_chk (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus_in),
   .rdata_out(rdata_out), .sck_out(sck_out), .irq_tx_out(irq_tx_out),
   .irq_rx_out(irq_rx_out), .irq_out(irq_out));

// *** dv/sbs_spi_peer.sv ***
module sbs_spi_peer (
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic [7:0] tx_in,
   input wire logic load_in,
   output logic miso_out,
   output logic [7:0] rx_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh_q = 8'h00;
   // Master data taken on the rising bit-clock edge, most significant bit first
   always @(posedge sck_in) rx_out <= {rx_out[6:0], mosi_in};
   // Next bit on the falling edge; refill with inverted bits so stale data never looks valid
   always @(negedge sck_in or posedge load_in) begin
      if (load_in) sh_q <= tx_in;
      else sh_q <= {sh_q[6:0], ~sh_q[7]};
   end
   assign miso_out = sh_q[7];
endmodule

// *** dv/testbench.sv ***
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import sbs_pkg::*;
   logic clk_in, nrst_in, ss_n, load, miso, sck, mosi, irq_tx, irq_rx, irq;
   logic [7:0] rdata, s_tx, s_rx, v;
   sbs_bus_t bus;
   int miscompares = 0, total_checks = 0, cyc = 0, n;
   logic [23:0] mf[4] = '{24'h521020, 24'h401020, 24'h500020, 24'hD01030};
   sbs_core u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus), .miso_in(miso),
      .ss_n_in(ss_n), .rdata_out(rdata), .sck_out(sck), .mosi_out(mosi),
      .irq_tx_out(irq_tx), .irq_rx_out(irq_rx), .irq_out(irq));
   sbs_spi_peer u_peer (.sck_in(sck), .mosi_in(mosi), .tx_in(s_tx), .load_in(load),
      .miso_out(miso), .rx_out(s_rx));
   // Bus clock, 20 ns
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // One access and an idle cycle; read data taken mid-cycle where it has settled
   task automatic acc(input logic [2:0] a, input logic [7:0] d, input logic w);
      bus <= '{a, d, w, !w};
      @(posedge clk_in);
      bus <= '0;
      @(negedge clk_in);
      v = rdata;
      @(posedge clk_in);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      acc(a, 8'h00, 1'b0);
      chk(v, e);
   endtask
   task automatic wait_lvl(ref logic s, input logic l);
      n = 0;
      while (s !== l && n < 3000) begin
         @(negedge clk_in);
         n++;
      end
   endtask
   // Byte done raises irq; back onto a rising edge, then acknowledge it
   task automatic done(input logic [7:0] st);
      wait_lvl(irq, 1'b1);
      @(posedge clk_in);
      rd(ADDR_IRQ_STAT, 8'h01);
      acc(ADDR_IRQ_CLR, 8'h01, 1'b1);
      rd(ADDR_STATUS, st);
      chk(8'(irq), 8'h00);
   endtask
   task automatic xfer(input logic [7:0] br, input logic [7:0] tx, input int half);
      acc(ADDR_RATE, br, 1'b1);
      s_tx <= ~tx;
      load <= 1'b1;
      rd(ADDR_STATUS, 8'h20);
      load <= 1'b0;
      acc(ADDR_DATA, tx, 1'b1);
      rd(ADDR_STATUS, 8'h20);
      wait_lvl(sck, 1'b0);
      wait_lvl(sck, 1'b1);
      wait_lvl(sck, 1'b0);
      chk(8'(n), 8'(half));
      done(8'hA0);
      chk(s_rx, tx);
      // Fastest rates leave the input synchroniser no margin, so data is not judged there
      if (half > 3) rd(ADDR_DATA, ~tx);
      else acc(ADDR_DATA, 8'h00, 1'b0);
      rd(ADDR_STATUS, 8'h20);
   endtask
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Hang guard, well above the expected run length
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 40000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      nrst_in = 1'b0;
      bus = '0;
      ss_n = 1'b1;
      load = 1'b0;
      s_tx = 8'h00;
      repeat (10) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      rd(ADDR_STATUS, 8'h20);
      rd(ADDR_RATE, BR_RESET);
      acc(ADDR_IRQ_EN, 8'h01, 1'b1);
      acc(ADDR_CTRL1, 8'h70, 1'b1);
      acc(ADDR_STATUS, 8'hFF, 1'b1);
      rd(ADDR_STATUS, 8'h20);
      acc(ADDR_RATE, 8'hFF, 1'b1);
      rd(ADDR_RATE, BR_MASK);
      chk(8'(irq_tx), 8'h01);
      for (int i = 0; i < 8; i++) begin
         xfer(8'(i << 4), 8'hA5 ^ 8'(i), i + 1);
         xfer(8'(i), 8'h3C ^ 8'(i), 1 << i);
      end
      // Idle write goes straight on, an unarmed write is dropped, the next one queues
      acc(ADDR_RATE, 8'h31, 1'b1);
      rd(ADDR_STATUS, 8'h20);
      acc(ADDR_DATA, 8'h81, 1'b1);
      acc(ADDR_DATA, 8'h66, 1'b1);
      rd(ADDR_STATUS, 8'h20);
      acc(ADDR_DATA, 8'h7E, 1'b1);
      rd(ADDR_STATUS, 8'h00);
      chk(8'(irq_tx), 8'h00);
      done(8'hA0);
      done(8'hA0);
      chk(s_rx, 8'h7E);
      // Disable in mid-byte with the receive buffer still full
      acc(ADDR_RATE, 8'h07, 1'b1);
      acc(ADDR_DATA, 8'h55, 1'b1);
      repeat (300) @(posedge clk_in);
      acc(ADDR_CTRL1, 8'h10, 1'b1);
      rd(ADDR_STATUS, 8'h20);
      chk(8'(sck), 8'h00);
      // Select pulsed low under each setup; only the last one may fault
      for (int i = 0; i < 4; i++) begin
         acc(ADDR_CTRL1, mf[i][23:16], 1'b1);
         acc(ADDR_CTRL2, mf[i][15:8], 1'b1);
         ss_n <= 1'b0;
         repeat (4) @(posedge clk_in);
         ss_n <= 1'b1;
         rd(ADDR_STATUS, mf[i][7:0]);
      end
      chk(8'(irq_rx), 8'h01);
      acc(ADDR_CTRL1, 8'hD0, 1'b1);
      rd(ADDR_STATUS, 8'h20);
      chk(8'(irq_rx), 8'h00);
      end_of_test();
   end
endmodule
